// ==== hdl/sfl_defs.svh ====
// Purpose: Shared constants of the serial FIFO link.
// Assumes: Included by its bare name, once per compile unit.
// Notes: Widths, depth, bit positions, reset values and timing counts.
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH
`define SFL_BYTE_W 8
`define SFL_FIFO_DEPTH 1024
`define SFL_IRQ_TX_BIT 1
`define SFL_IRQ_RX_BIT 2
`define SFL_IRQ_PATTERN_BIT 3
`define SFL_IRQ_MASK 8'h0E
`define SFL_IRQ_RESET 8'h00
`define SFL_EMPTY_RESET 1'b1
`define SFL_CHAR_TICKS 8
`endif

// ==== hdl/sfl_pkg.sv ====
// Purpose: Types of the serial FIFO link.
// Assumes: sfl_defs.svh supplies the widths.
// Notes: The link and the receive monitor keep their whole state in these structs; the FIFO uses its own.
`include "sfl_defs.svh"
package sfl_pkg;
   // Which controller channel feeds the receive FIFO.
   typedef enum logic {
      SFL_SRC_CHAN_A = 1'b0,
      SFL_SRC_CHAN_B = 1'b1
   } sfl_rx_src_t;

   // State of the top module.
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [`SFL_BYTE_W-1:0] d1;
      logic [`SFL_BYTE_W-1:0] d2;
      logic fifo_en;
      logic [`SFL_BYTE_W-1:0] tx_data;
      logic tx_strobe;
      logic rx_ack;
      logic [`SFL_BYTE_W-1:0] rd_data;
      logic rd_valid;
      logic [7:0] irq;
      logic host_irq;
      logic tx_empty;
      logic tx_full;
      logic tx_half;
      logic rx_empty;
      logic rx_full;
      logic rx_half;
      logic tx_above;
   } sfl_link_t;

   // State of the receive monitor.
   typedef struct packed {
      logic [3:0] run;
      logic [2:0] ticks;
      logic [7:0] chars;
      logic expired;
      logic pattern_hit;
      logic timeout_hit;
   } sfl_mon_t;
endpackage

// ==== hdl/sfl_fifo.sv ====
// Purpose: Byte FIFO with count, empty and full.
// Assumes: DEPTH is a power of two; push and pop may share a cycle.
// Notes: Head byte is shown combinationally on rdata.
`include "sfl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module sfl_fifo #(
   parameter int WIDTH = `SFL_BYTE_W,
   parameter int DEPTH = `SFL_FIFO_DEPTH,
   localparam int AW = $clog2(DEPTH),
   localparam int CW = AW + 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic push,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic pop,
   output logic [WIDTH-1:0] rdata,
   output logic [CW-1:0] count,
   output logic empty,
   output logic full
);
   import sfl_pkg::*;

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } sfl_fifo_t;

   sfl_fifo_t fifo_reg;
   sfl_fifo_t fifo_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic do_push;
   logic do_pop;

   if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < 4) begin : g_chk
      $error("sfl_fifo: DEPTH must be a power of two, at least 4");
   end

   // Flags and guarded strobes; a full FIFO drops a push.
   assign empty = (fifo_reg.cnt == '0);
   assign full = (fifo_reg.cnt == CW'(DEPTH));
   assign count = fifo_reg.cnt;
   assign rdata = mem[fifo_reg.rp];
   assign do_push = push & ~full & ~clear;
   assign do_pop = pop & ~empty & ~clear;

   // Pointer and count update; clear empties the FIFO at once.
   always_comb begin
      fifo_next = fifo_reg;
      if (clear) begin
         fifo_next = '0;
      end else begin
         fifo_next.wp = fifo_reg.wp + AW'(do_push);
         fifo_next.rp = fifo_reg.rp + AW'(do_pop);
         fifo_next.cnt = fifo_reg.cnt + CW'(do_push) - CW'(do_pop);
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fifo_reg <= '0;
      end else begin
         fifo_reg <= fifo_next;
      end
   end

   // Storage needs no reset; only written slots are ever read.
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[fifo_reg.wp] <= wdata;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/sfl_rx_monitor.sv ====
// Purpose: Receive pattern detector and receive idle timeout.
// Assumes: push marks a byte entering the receive FIFO.
// Notes: Outputs are one-cycle pulses from flip-flops.
`include "sfl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module sfl_rx_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire logic push,
   input wire logic [7:0] data,
   input wire logic pattern_en,
   input wire logic [7:0] pattern_char,
   input wire logic [3:0] pattern_repeat,
   input wire logic timeout_en,
   input wire logic [7:0] timeout_chars,
   input wire logic bit_tick,
   input wire logic nonempty,
   input wire logic below_half,
   output logic pattern_hit,
   output logic timeout_hit
);
   import sfl_pkg::*;

   sfl_mon_t mon_reg;
   sfl_mon_t mon_next;
   logic match;

   assign match = push & (data == pattern_char);
   assign pattern_hit = mon_reg.pattern_hit;
   assign timeout_hit = mon_reg.timeout_hit;

   // Run length of the watched byte, then the idle timer in character times.
   always_comb begin
      mon_next = mon_reg;
      mon_next.pattern_hit = 1'b0;
      mon_next.timeout_hit = 1'b0;
      if (push) begin
         mon_next.run = match ? mon_reg.run + 4'h1 : 4'h0;
      end
      // A repeat count of zero never fires, even when the run counter wraps.
      if (pattern_en && match && pattern_repeat != 4'h0 &&
          (mon_reg.run + 4'h1 == pattern_repeat)) begin
         mon_next.pattern_hit = 1'b1; // R12
         mon_next.run = 4'h0;
      end
      if (push || !nonempty || !timeout_en) begin
         mon_next.ticks = 3'h0;
         mon_next.chars = 8'h00;
         mon_next.expired = 1'b0;
      end else if (bit_tick) begin
         mon_next.ticks = mon_reg.ticks + 3'h1;
         if (mon_reg.ticks == 3'(`SFL_CHAR_TICKS - 1)) begin
            mon_next.chars = mon_reg.chars + 8'h01;
            if (mon_reg.chars + 8'h01 == timeout_chars && !mon_reg.expired) begin
               mon_next.expired = 1'b1;
               // A FIFO at or past half full is left to the half-full event.
               mon_next.timeout_hit = below_half; // R11 R15
            end
         end
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mon_reg <= '0;
      end else begin
         mon_reg <= mon_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_timeout_below_half;
      timeout_hit |-> $past(below_half) && $past(nonempty);
   endproperty
   a_timeout_below_half: assert property (p_timeout_below_half) // R15
      else $error("timeout fired at or past half full or on empty FIFO");

   cover property (pattern_hit);
   cover property (timeout_hit);
endmodule
`default_nettype wire

// ==== hdl/sfl_link.sv ====
// Purpose: Byte FIFOs between the serial controller request lines and the host.
// Assumes: One 25 MHz clock; request lines, data and bit clock are pins.
// Notes: One byte moves per rising edge of a request line.
// Notes on behaviour
// [R1] Select 0: channel A wait line fills receive, terminal-ready line drains transmit.
// [R2] Select 1: channel A wait line drains transmit, channel B wait line fills receive.
// [R3] Software sets channel A wait config bits 7,6,5; bit 7 last.
// [R4] Receiving channel config bits 4-3 are 11 or 00; bit 1 is 0.
// [R5] Misc control bit 2 is 1 for channel A receive, else 0.
// [R6] Software exposes extended options, then clears bit 5 there.
// [R7] Channel A receive: extended options bit 4 set, matching request timing.
// [R8] Channel B receive: channel B wait config bits 7,6,5 set.
// [R9] Transmit flag, status bit 1, latches when transmit FIFO drains below half; the code latches when it drains to exactly half.
// [R10] Receive flag, status bit 2, latches when receive FIFO reaches half.
// [R11] Receive flag also latches on idle timeout with bytes waiting.
// [R12] Pattern flag, status bit 3, latches when the pattern detector fires.
// [R13] Flags stay set until software writes one to their bit.
// [R14] FIFO interrupts reach the host only with serial controller source selected.
// [R15] Receive half-full reads 0 whenever the receive flag came from timeout.
// [R16] Reset disables both FIFOs and empties them.
// [R17] A FIFO reset bit clears only its own FIFO.
// [R18] FIFO resets are ignored while the FIFOs are enabled.
// [R19] Empty, full and half-or-more status of both FIFOs is always shown.
// [R20] Control inputs give both FIFO resets, pattern and timeout enables.
// [R21] Each FIFO holds 1024 bytes.
// [R22] Enabled: host write pushes transmit FIFO, host read pops receive FIFO.
// [R23] One enable switches both FIFOs together.
// [R24] Each request moves one byte when the FIFO can take or give it.
`include "sfl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module sfl_link #(
   parameter int DEPTH = `SFL_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic fifo_enable,
   input wire sfl_pkg::sfl_rx_src_t receive_source_select,
   input wire logic irq_source_serial_controller,
   input wire logic tx_fifo_reset,
   input wire logic rx_fifo_reset,
   input wire logic pattern_detect_enable,
   input wire logic [7:0] pattern_char,
   input wire logic [3:0] pattern_repeat,
   input wire logic rx_timeout_enable,
   input wire logic [7:0] timeout_chars,
   input wire logic irq_status_write,
   input wire logic [7:0] irq_status_wdata,
   input wire logic host_write,
   input wire logic [7:0] host_wdata,
   input wire logic host_read,
   input wire logic chan_a_wait_request_line,
   input wire logic chan_a_terminal_ready_request_line,
   input wire logic chan_b_wait_request_line,
   input wire logic rx_bit_clock,
   input wire logic [7:0] serial_rx_data,
   output logic [7:0] host_rdata,
   output logic host_rdata_valid,
   output logic [7:0] serial_tx_data,
   output logic serial_tx_strobe,
   output logic serial_rx_ack,
   output logic [7:0] irq_status,
   output logic host_irq,
   output logic tx_fifo_empty,
   output logic tx_fifo_full,
   output logic tx_fifo_half,
   output logic rx_fifo_empty,
   output logic rx_fifo_full,
   output logic rx_half_full_status
);
   import sfl_pkg::*;

   localparam int CW = $clog2(DEPTH) + 1;
   localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);

   if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < 4) begin : g_chk
      $error("sfl_link: DEPTH must be a power of two, at least 4");
   end

   sfl_link_t link_reg;
   sfl_link_t link_next;
   logic [3:0] rise;
   logic tx_req;
   logic rx_req;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic tx_clear;
   logic rx_clear;
   logic [7:0] tx_head;
   logic [7:0] rx_head;
   logic [CW-1:0] tx_count;
   logic [CW-1:0] rx_count;
   logic tx_empty;
   logic tx_full;
   logic rx_empty;
   logic rx_full;
   logic pattern_hit;
   logic timeout_hit;
   logic tx_cross;
   logic rx_cross;
   logic [7:0] irq_set;
   logic [7:0] irq_clr;

   // Rising edges of the synchronised pins: wait A, ready A, wait B, bit clock.
   assign rise = link_reg.s2 & ~link_reg.s3;

   // Route the request lines to the FIFOs by the receive source.
   assign tx_req = (receive_source_select == SFL_SRC_CHAN_B) ? rise[0] : rise[1]; // R1 R2
   assign rx_req = (receive_source_select == SFL_SRC_CHAN_B) ? rise[2] : rise[0]; // R1 R2

   // Transfers happen only while enabled and only when the FIFO can serve.
   assign tx_pop = link_reg.fifo_en & tx_req & ~tx_empty; // R24
   assign rx_push = link_reg.fifo_en & rx_req & ~rx_full; // R24
   assign tx_push = link_reg.fifo_en & host_write & ~tx_full; // R22
   assign rx_pop = link_reg.fifo_en & host_read & ~rx_empty; // R22

   // Reset bits act only while the FIFOs are off, and each on its own FIFO.
   assign tx_clear = ~link_reg.fifo_en & tx_fifo_reset; // R17 R18 R20
   assign rx_clear = ~link_reg.fifo_en & rx_fifo_reset; // R17 R18 R20

   // Half-mark crossings against last cycle's level.
   assign tx_cross = link_reg.tx_above & (tx_count <= HALF); // R9
   assign rx_cross = ~link_reg.rx_half & (rx_count >= HALF); // R10

   // Flag events and write-one clears; an event in the clear cycle wins.
   always_comb begin
      irq_set = 8'h00;
      irq_set[`SFL_IRQ_TX_BIT] = tx_cross; // R9
      irq_set[`SFL_IRQ_RX_BIT] = rx_cross | timeout_hit; // R10 R11
      irq_set[`SFL_IRQ_PATTERN_BIT] = pattern_hit; // R12
      irq_clr = irq_status_write ? irq_status_wdata : 8'h00; // R13
   end

   // Transmit FIFO: host fills, controller drains.
   sfl_fifo #(
      .WIDTH(8),
      .DEPTH(DEPTH)
   ) u_tx_fifo (
      .clk(clk),
      .resetn(resetn),
      .clear(tx_clear),
      .push(tx_push),
      .wdata(host_wdata),
      .pop(tx_pop),
      .rdata(tx_head),
      .count(tx_count),
      .empty(tx_empty),
      .full(tx_full)
   ); // R21

   // Receive FIFO: controller fills, host drains.
   sfl_fifo #(
      .WIDTH(8),
      .DEPTH(DEPTH)
   ) u_rx_fifo (
      .clk(clk),
      .resetn(resetn),
      .clear(rx_clear),
      .push(rx_push),
      .wdata(link_reg.d2),
      .pop(rx_pop),
      .rdata(rx_head),
      .count(rx_count),
      .empty(rx_empty),
      .full(rx_full)
   ); // R21

   // Pattern detector and idle timeout on the receive stream.
   sfl_rx_monitor u_mon (
      .clk(clk),
      .resetn(resetn),
      .push(rx_push),
      .data(link_reg.d2),
      .pattern_en(pattern_detect_enable),
      .pattern_char(pattern_char),
      .pattern_repeat(pattern_repeat),
      .timeout_en(rx_timeout_enable),
      .timeout_chars(timeout_chars),
      .bit_tick(rise[3]),
      .nonempty(~rx_empty),
      .below_half(rx_count < HALF),
      .pattern_hit(pattern_hit),
      .timeout_hit(timeout_hit)
   );

   // Next state: synchronisers, transfer strobes, flags and status copies.
   always_comb begin
      link_next = link_reg;
      link_next.s1 = {rx_bit_clock, chan_b_wait_request_line,
                      chan_a_terminal_ready_request_line, chan_a_wait_request_line};
      link_next.s2 = link_reg.s1;
      link_next.s3 = link_reg.s2;
      link_next.d1 = serial_rx_data;
      link_next.d2 = link_reg.d1;
      link_next.fifo_en = fifo_enable; // R23
      link_next.tx_strobe = tx_pop; // R24
      link_next.rx_ack = rx_push; // R24
      if (tx_pop) begin
         link_next.tx_data = tx_head;
      end
      link_next.rd_valid = rx_pop; // R22
      if (rx_pop) begin
         link_next.rd_data = rx_head;
      end
      link_next.irq = ((link_reg.irq & ~irq_clr) | irq_set) & `SFL_IRQ_MASK; // R13
      link_next.host_irq = irq_source_serial_controller & (|link_next.irq); // R14
      link_next.tx_empty = tx_empty; // R19
      link_next.tx_full = tx_full; // R19
      link_next.tx_half = tx_count >= HALF; // R19
      link_next.rx_empty = rx_empty; // R19
      link_next.rx_full = rx_full; // R19
      link_next.rx_half = rx_count >= HALF; // R15 R19
      link_next.tx_above = tx_count > HALF;
   end

   // State register; reset leaves the FIFOs off and empty.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         link_reg <= '0; // R16
         link_reg.irq <= `SFL_IRQ_RESET;
         link_reg.tx_empty <= `SFL_EMPTY_RESET;
         link_reg.rx_empty <= `SFL_EMPTY_RESET;
      end else begin
         link_reg <= link_next;
      end
   end

   // Outputs straight from the state register.
   assign host_rdata = link_reg.rd_data;
   assign host_rdata_valid = link_reg.rd_valid;
   assign serial_tx_data = link_reg.tx_data;
   assign serial_tx_strobe = link_reg.tx_strobe;
   assign serial_rx_ack = link_reg.rx_ack;
   assign irq_status = link_reg.irq;
   assign host_irq = link_reg.host_irq;
   assign tx_fifo_empty = link_reg.tx_empty;
   assign tx_fifo_full = link_reg.tx_full;
   assign tx_fifo_half = link_reg.tx_half;
   assign rx_fifo_empty = link_reg.rx_empty;
   assign rx_fifo_full = link_reg.rx_full;
   assign rx_half_full_status = link_reg.rx_half;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_src_a_rx;
      (link_reg.fifo_en && receive_source_select == SFL_SRC_CHAN_A && rise[0] && !rx_full)
         |=> serial_rx_ack;
   endproperty
   a_src_a_rx: assert property (p_src_a_rx) // R1
      else $error("channel A wait edge did not fill receive FIFO");

   property p_src_a_tx;
      (link_reg.fifo_en && receive_source_select == SFL_SRC_CHAN_A && rise[1] && !tx_empty)
         |=> serial_tx_strobe && serial_tx_data == $past(tx_head);
   endproperty
   a_src_a_tx: assert property (p_src_a_tx) // R1
      else $error("ready edge did not drain transmit FIFO head");

   property p_src_b;
      (link_reg.fifo_en && receive_source_select == SFL_SRC_CHAN_B && rise[2] && !rise[0])
         |=> serial_rx_ack != $past(rx_full) && !serial_tx_strobe;
   endproperty
   a_src_b: assert property (p_src_b) // R2
      else $error("channel B wait edge handled wrongly");

   property p_tx_flag;
      tx_cross |=> irq_status[`SFL_IRQ_TX_BIT] ##1
         (host_irq == $past(irq_source_serial_controller) || $past(irq_status_write));
   endproperty
   a_tx_flag: assert property (p_tx_flag) // R9
      else $error("transmit half mark flag not latched");

   property p_rx_flag;
      rx_cross |=> irq_status[`SFL_IRQ_RX_BIT] && rx_half_full_status;
   endproperty
   a_rx_flag: assert property (p_rx_flag) // R10
      else $error("receive half mark flag not latched");

   property p_sticky;
      (irq_status[`SFL_IRQ_PATTERN_BIT] && !(irq_status_write && irq_status_wdata[3]))
         |=> irq_status[`SFL_IRQ_PATTERN_BIT];
   endproperty
   a_sticky: assert property (p_sticky) // R13
      else $error("pattern flag dropped without a clear");

   property p_clear;
      (irq_status_write && irq_status_wdata[1] && !tx_cross) |=> !irq_status[`SFL_IRQ_TX_BIT];
   endproperty
   a_clear: assert property (p_clear) // R13
      else $error("write one did not clear transmit flag");

   property p_gate;
      host_irq |-> $past(irq_source_serial_controller) && irq_status != 8'h00;
   endproperty
   a_gate: assert property (p_gate) // R14
      else $error("host interrupt without serial controller source");

   property p_reset_ignored;
      (link_reg.fifo_en && tx_fifo_reset && tx_count > CW'(1)) |=> tx_count != '0;
   endproperty
   a_reset_ignored: assert property (p_reset_ignored) // R18
      else $error("transmit FIFO reset while enabled");

   property p_reset_works;
      (!link_reg.fifo_en && rx_fifo_reset) |=> rx_count == '0 ##1 rx_fifo_empty;
   endproperty
   a_reset_works: assert property (p_reset_works) // R17
      else $error("receive FIFO reset did not empty it");

   cover property (serial_tx_strobe ##1 serial_rx_ack);
   cover property (host_rdata_valid && rx_half_full_status);
   cover property (host_irq && irq_status[`SFL_IRQ_PATTERN_BIT]);
endmodule
`default_nettype wire

// ==== testbench/sfl_ctl_model.sv ====
// Purpose: Serial controller side of the link: request pins, data, bit clock.
// Assumes: The controller is set up so that its request pins act as DMA requests.
// Notes: Pins idle low; receive data turns to its inverse two cycles after its request falls.
`timescale 1ns/1ns
`default_nettype none
module sfl_ctl_model (
   input wire logic clk,
   output logic chan_a_wait_request_line,
   output logic chan_a_terminal_ready_request_line,
   output logic chan_b_wait_request_line,
   output logic rx_bit_clock,
   output logic [7:0] serial_rx_data
);
   logic [2:0] req_lines;
   // Line 0 is channel A wait, 1 channel A terminal ready, 2 channel B wait.
   assign chan_a_wait_request_line = req_lines[0];
   assign chan_a_terminal_ready_request_line = req_lines[1];
   assign chan_b_wait_request_line = req_lines[2];
   // All pins start idle and the bit clock stands still.
   initial begin
      req_lines = 3'h0;
      rx_bit_clock = 1'b0;
      serial_rx_data = 8'h00;
   end
   // One request per byte; a larger hold gives a slow controller.
   task automatic req(input int line, input int hold, input logic [7:0] d);
      serial_rx_data <= d;
      @(posedge clk);
      req_lines[line] <= 1'b1;
      repeat (hold) @(posedge clk);
      req_lines[line] <= 1'b0;
      repeat (2) @(posedge clk);
      serial_rx_data <= ~d;
      repeat (hold) @(posedge clk);
   endtask
   // Runs the bit clock for n periods of four clock cycles.
   task automatic tick(input int n);
      repeat (n) begin
         rx_bit_clock <= 1'b1;
         repeat (2) @(posedge clk);
         rx_bit_clock <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench of the serial FIFO link.
// Assumes: FIFO depth is 16, so half full is 8 bytes.
// Notes: Inputs change on the rising edge by non-blocking assignment.
`include "sfl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import sfl_pkg::*;
   localparam int DEPTH = 16;
   logic clk, resetn, fifo_enable, irq_src, tx_rst, rx_rst, pat_en, to_en;
   sfl_rx_src_t rx_src;
   logic [7:0] pat_char, to_chars, irq_wdata, host_wdata, host_rdata, tx_data, irq_status;
   logic [3:0] pat_rep;
   logic irq_wr, host_write, host_read, rd_valid, tx_strobe, rx_ack, host_irq;
   logic req_aw, req_at, req_bw, bit_clk;
   logic [7:0] rx_data;
   logic tx_empty, tx_full, tx_half, rx_empty, rx_full, rx_half;
   logic [7:0] txq[$];
   logic [7:0] rdq[$];
   int fails = 0;
   int check_count = 0;
   int acks = 0;

   sfl_link #(.DEPTH(DEPTH)) dut_u (.clk(clk), .resetn(resetn), .fifo_enable(fifo_enable),
      .receive_source_select(rx_src), .irq_source_serial_controller(irq_src),
      .tx_fifo_reset(tx_rst), .rx_fifo_reset(rx_rst), .pattern_detect_enable(pat_en),
      .pattern_char(pat_char), .pattern_repeat(pat_rep), .rx_timeout_enable(to_en),
      .timeout_chars(to_chars), .irq_status_write(irq_wr), .irq_status_wdata(irq_wdata),
      .host_write(host_write), .host_wdata(host_wdata), .host_read(host_read),
      .chan_a_wait_request_line(req_aw), .chan_a_terminal_ready_request_line(req_at),
      .chan_b_wait_request_line(req_bw), .rx_bit_clock(bit_clk), .serial_rx_data(rx_data),
      .host_rdata(host_rdata), .host_rdata_valid(rd_valid), .serial_tx_data(tx_data),
      .serial_tx_strobe(tx_strobe), .serial_rx_ack(rx_ack), .irq_status(irq_status),
      .host_irq(host_irq), .tx_fifo_empty(tx_empty), .tx_fifo_full(tx_full),
      .tx_fifo_half(tx_half), .rx_fifo_empty(rx_empty), .rx_fifo_full(rx_full),
      .rx_half_full_status(rx_half));

   sfl_ctl_model ctl_u (.clk(clk), .chan_a_wait_request_line(req_aw),
      .chan_a_terminal_ready_request_line(req_at), .chan_b_wait_request_line(req_bw),
      .rx_bit_clock(bit_clk), .serial_rx_data(rx_data));

   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Collects bytes handed to the controller and bytes read by the host.
   always @(posedge clk) begin
      if (tx_strobe === 1'b1) txq.push_back(tx_data);
      if (rd_valid === 1'b1) rdq.push_back(host_rdata);
      if (rx_ack === 1'b1) acks++;
   end

   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Waits a bounded time for n bytes to reach the controller.
   task automatic wtx(input int n);
      int k;
      k = 0;
      while (txq.size() < n && k < 30) begin
         @(posedge clk);
         k++;
      end
      if (txq.size() < n) begin
         fails++;
         print_verdict();
      end
   endtask

   task automatic hw(input logic [7:0] d);
      host_wdata <= d;
      host_write <= 1'b1;
      cyc(1);
      host_write <= 1'b0;
      cyc(1);
   endtask

   // The extra cycle lets the collector take the byte before anyone looks at it.
   task automatic hr();
      host_read <= 1'b1;
      cyc(1);
      host_read <= 1'b0;
      cyc(2);
   endtask

   task automatic clr(input logic [7:0] m);
      irq_wdata <= m;
      irq_wr <= 1'b1;
      cyc(1);
      irq_wr <= 1'b0;
      cyc(3);
   endtask

   task automatic t_reset();
      chk("tx_empty", tx_empty, 1);
      chk("rx_empty", rx_empty, 1);
      chk("irq", {host_irq, irq_status[6:0]}, 8'h00);
   endtask

   task automatic t_off();
      hw(8'h11);
      ctl_u.req(0, 3, 8'h22);
      chk("tx_empty", tx_empty, 1);
      chk("rx_empty", rx_empty, 1);
   endtask

   task automatic t_chan_a();
      fifo_enable <= 1'b1;
      cyc(2);
      hw(8'hA1);
      hw(8'hA2);
      cyc(2);
      chk("tx_empty", tx_empty, 0);
      ctl_u.req(1, 3, 8'h00);
      wtx(1);
      chk("tx_byte", txq[0], 8'hA1);
      ctl_u.req(0, 3, 8'h5A);
      hr();
      chk("rd_byte", rdq[0], 8'h5A);
   endtask

   task automatic t_chan_b();
      rx_src <= SFL_SRC_CHAN_B;
      cyc(2);
      ctl_u.req(0, 5, 8'h00);
      wtx(2);
      chk("tx_byte", txq[1], 8'hA2);
      ctl_u.req(2, 3, 8'hC3);
      hr();
      chk("rd_byte", rdq[1], 8'hC3);
   endtask

   task automatic t_tx_flag();
      for (int i = 0; i < DEPTH; i++) hw(8'(i));
      hw(8'hEE);
      cyc(2);
      chk("tx_full", {tx_full, tx_half}, 8'h03);
      for (int i = 0; i < DEPTH / 2; i++) begin
         chk("irq", irq_status, 8'h00);
         ctl_u.req(0, 3, 8'h00);
         wtx(3 + i);
         chk("tx_byte", txq[2 + i], 8'(i));
      end
      chk("tx_irq", irq_status[`SFL_IRQ_TX_BIT], 1);
      chk("host_irq", host_irq, 0);
      irq_src <= 1'b1;
      cyc(3);
      chk("host_irq", host_irq, 1);
      clr(8'h08);
      chk("tx_irq", irq_status[`SFL_IRQ_TX_BIT], 1);
      clr(8'h02);
      chk("irq", {host_irq, irq_status[6:0]}, 8'h00);
   endtask

   task automatic t_rx_flag();
      rx_src <= SFL_SRC_CHAN_A;
      cyc(2);
      for (int i = 0; i < DEPTH / 2; i++) begin
         chk("rx_irq", irq_status[`SFL_IRQ_RX_BIT], 0);
         ctl_u.req(0, 3, 8'(16 + i));
      end
      chk("rx_irq", irq_status[`SFL_IRQ_RX_BIT], 1);
      chk("rx_half", rx_half, 1);
      chk("rx_acks", 8'(acks), 8'h0A);
      clr(8'h04);
      for (int i = 0; i < DEPTH / 2; i++) begin
         hr();
         chk("rd_byte", rdq[2 + i], 8'(16 + i));
      end
      cyc(2);
      chk("rx_empty", rx_empty, 1);
   endtask

   task automatic t_pattern();
      pat_en <= 1'b1;
      cyc(2);
      ctl_u.req(0, 3, 8'h7E);
      ctl_u.req(0, 3, 8'h41);
      ctl_u.req(0, 3, 8'h7E);
      chk("pat_irq", irq_status[`SFL_IRQ_PATTERN_BIT], 0);
      ctl_u.req(0, 3, 8'h7E);
      chk("pat_irq", irq_status[`SFL_IRQ_PATTERN_BIT], 1);
      clr(8'h08);
      pat_en <= 1'b0;
   endtask

   task automatic t_timeout();
      to_en <= 1'b1;
      cyc(2);
      chk("rx_irq", irq_status[`SFL_IRQ_RX_BIT], 0);
      ctl_u.tick(12);
      cyc(4);
      chk("rx_irq", irq_status[`SFL_IRQ_RX_BIT], 1);
      chk("rx_half", rx_half, 0);
      clr(8'h04);
      to_en <= 1'b0;
      for (int i = 0; i < DEPTH - 4; i++) ctl_u.req(0, 2, 8'h00);
      chk("rx_full", rx_full, 1);
   endtask

   task automatic t_fifo_reset();
      tx_rst <= 1'b1;
      cyc(3);
      tx_rst <= 1'b0;
      cyc(3);
      chk("tx_empty", tx_empty, 0);
      fifo_enable <= 1'b0;
      cyc(3);
      rx_rst <= 1'b1;
      cyc(3);
      rx_rst <= 1'b0;
      cyc(3);
      chk("rx_empty", rx_empty, 1);
      chk("tx_empty", tx_empty, 0);
      tx_rst <= 1'b1;
      cyc(3);
      tx_rst <= 1'b0;
      cyc(3);
      chk("tx_empty", tx_empty, 1);
   endtask

   // Main sequence: reset for 20 cycles, then every scenario in turn.
   initial begin
      {fifo_enable, irq_src, tx_rst, rx_rst, pat_en, to_en} = 6'h00;
      {irq_wr, host_write, host_read, resetn} = 4'h0;
      rx_src = SFL_SRC_CHAN_A;
      pat_char = 8'h7E;
      pat_rep = 4'h2;
      to_chars = 8'h01;
      irq_wdata = 8'h00;
      host_wdata = 8'h00;
      cyc(20);
      resetn <= 1'b1;
      cyc(1);
      t_reset();
      t_off();
      t_chan_a();
      t_chan_b();
      t_tx_flag();
      t_rx_flag();
      t_pattern();
      t_timeout();
      t_fifo_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
